//--- src/lpm_map.vh
// Mode codes, register offsets, field positions and timing constants.
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
`define LPM_MODE_INIT 3'h0
`define LPM_MODE_NORMAL 3'h1
`define LPM_MODE_STOP 3'h2
`define LPM_MODE_SLEEP 3'h3
`define LPM_MODE_RESTART 3'h4
`define LPM_MODE_FAILSAFE 3'h5
`define LPM_CMD_NORMAL 2'h0
`define LPM_CMD_STOP 2'h1
`define LPM_CMD_SLEEP 2'h2
`define LPM_CMD_SOFTRST 2'h3
`define LPM_REG_MODE 4'h0
`define LPM_REG_CFG 4'h1
`define LPM_REG_STATUS 4'h2
`define LPM_REG_WAKE 4'h3
`define LPM_REG_LSBRK 4'h4
`define LPM_REG_RELEASE 4'h5
`define LPM_CFG_WD 0
`define LPM_CFG_HS 1
`define LPM_CFG_BD 2
`define LPM_CFG_CP 3
`define LPM_CFG_CAN 4
`define LPM_CFG_LIN 5
`define LPM_CFG_CSENSE 6
`define LPM_CFG_CWAKE 7
`define LPM_CFG_WKIN 8
`define LPM_CFG_FO 9
`define LPM_CFG_PARK 10
`define LPM_CFG_RESET 11'h000
`define LPM_STAT_CMDERR 3
`define LPM_STAT_TSD 4
`define LPM_STAT_DWELL 5
`define LPM_DWELL_MS 100
`define LPM_TSD_DELAY_MS 1000
`define LPM_CLK_KHZ 100000
`endif

//--- src/lpm_mode_ctrl.v
// Low-power and fail-safe operating mode controller.
// Notes on behaviour
// - Stop: regulator on, other functions stay configured.
// - Stop: bridge and pump off, low sides allowed.
// - Sleep: regulator, timer off; bridge, pump off.
// - Sleep: transceivers keep wake-capable or off setting.
// - Sleep: bridge low sides may still brake.
// - Restart holds the reset output asserted.
// - Restart: functions off, regulator on or ramping.
// - Restart: transceiver woken, wake-capable or off.
// - Fail-safe switches every supplied function off.
// - Fail-safe forces both transceivers wake-capable.
// - Fail-safe entry clears wake flags; wake inputs stay as configured.
// - Fail-safe entry activates configured fail output.
// - Fail-safe lasts dwell time and until wake or thermal recovery.
// - Dwell wakes latched; restart after dwell expiry.
// - After thermal shutdown, restart one second after cooling.
// - Fail-safe entry disables parking braking.
// - Stop ignores writes except mode and status, sets command error.
// - Mode field 11 soft-resets into Init.
// - Accepted Sleep command drops reset output at once.
`include "lpm_map.vh"
module lpm_mode_ctrl #(
  parameter DWELL_CYC = `LPM_DWELL_MS * `LPM_CLK_KHZ,
  parameter TSD_CYC = `LPM_TSD_DELAY_MS * `LPM_CLK_KHZ
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Fault and wake inputs from the analog side
  input wire fail_req,
  input wire regulator_thermal_shutdown,
  input wire can_wake,
  input wire lin_wake,
  input wire wake_inputs,
  input wire brake_req,
  // Function enables
  output wire main_regulator_output,
  output wire supervision_timer,
  output wire high_side_switches,
  output wire bridge_drivers,
  output wire bridge_low_sides,
  output wire charge_pump,
  output wire cyclic_sense,
  output wire cyclic_wake,
  output wire [1:0] can_state,
  output wire [1:0] lin_state,
  output wire wake_inputs_en,
  output wire fail_output_wake_pin,
  output wire parking_brake,
  output wire reset_output_pin_n
);
  localparam TRX_OFF = 2'h0;
  localparam TRX_WAKECAP = 2'h1;
  localparam TRX_ON = 2'h2;
  localparam TRX_WOKEN = 2'h3;

  reg [2:0] mode_r;
  reg [2:0] mode_nxt;
  reg [10:0] cfg_r;
  reg cmd_err_r;
  reg tsd_seen_r;
  reg [2:0] wake_flags_r;
  reg fo_r;
  reg park_dis_r;
  reg trx_woken_r;
  reg reset_low_r;
  wire fail_s;
  wire tsd_s;
  wire can_s;
  wire lin_s;
  wire wk_s;
  wire brk_s;
  wire [5:0] raw_in;
  wire [5:0] syn_in;
  wire dwell_done;
  wire tsd_done;
  wire enter_fs;
  wire any_wake;
  wire wr_mode;

  assign raw_in = {fail_req, regulator_thermal_shutdown, can_wake, lin_wake, wake_inputs,
                   brake_req};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_sync
      lpm_sync3 u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d_in(raw_in[gi]),
        .q_out(syn_in[gi])
      );
    end
  endgenerate
  assign {fail_s, tsd_s, can_s, lin_s, wk_s, brk_s} = syn_in;

  // Maps a stored transceiver enable to its low-power state.
  function [1:0] lp_trx;
    input en;
    begin
      lp_trx = en ? TRX_WAKECAP : TRX_OFF;
    end
  endfunction

  assign wr_mode = reg_wr && (reg_addr == `LPM_REG_MODE);
  assign enter_fs = (fail_s || tsd_s) && (mode_r != `LPM_MODE_FAILSAFE);
  assign any_wake = (wake_flags_r != 3'h0);

  lpm_timer #(.CNT_W(28)) u_dwell (
    .clk(clk),
    .rst_n(rst_n),
    .load(enter_fs),
    .load_val(DWELL_CYC[27:0]),
    .run(mode_r == `LPM_MODE_FAILSAFE),
    .expired(dwell_done)
  );
  lpm_timer #(.CNT_W(28)) u_tsd (
    .clk(clk),
    .rst_n(rst_n),
    .load(tsd_s),
    .load_val(TSD_CYC[27:0]),
    .run(mode_r == `LPM_MODE_FAILSAFE),
    .expired(tsd_done)
  );

  // Next mode from commands, faults and fail-safe exit conditions.
  always @*
  begin
    mode_nxt = mode_r;
    if (enter_fs)
      mode_nxt = `LPM_MODE_FAILSAFE;
    else if (mode_r == `LPM_MODE_FAILSAFE)
    begin
      if (dwell_done && !tsd_s && tsd_seen_r && tsd_done)
        mode_nxt = `LPM_MODE_RESTART;
      else if (dwell_done && any_wake)
        mode_nxt = `LPM_MODE_RESTART;
    end
    else if (mode_r == `LPM_MODE_RESTART)
      mode_nxt = `LPM_MODE_INIT;
    else if (wr_mode)
    begin
      case (reg_wdata[1:0])
        `LPM_CMD_SOFTRST: mode_nxt = `LPM_MODE_INIT;
        `LPM_CMD_NORMAL: mode_nxt = `LPM_MODE_NORMAL;
        `LPM_CMD_STOP:
          if (mode_r == `LPM_MODE_NORMAL)
            mode_nxt = `LPM_MODE_STOP;
          else if (mode_r == `LPM_MODE_INIT)
            mode_nxt = `LPM_MODE_NORMAL;
        `LPM_CMD_SLEEP:
          if (mode_r == `LPM_MODE_NORMAL)
            mode_nxt = `LPM_MODE_SLEEP;
          else if (mode_r == `LPM_MODE_STOP)
            mode_nxt = `LPM_MODE_RESTART;
          else
            mode_nxt = `LPM_MODE_NORMAL;
        default: mode_nxt = mode_r;
      endcase
    end
  end

  // Mode, configuration and flags.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= `LPM_MODE_INIT;
      cfg_r <= `LPM_CFG_RESET;
      cmd_err_r <= 1'b0;
      tsd_seen_r <= 1'b0;
      wake_flags_r <= 3'h0;
      fo_r <= 1'b0;
      park_dis_r <= 1'b0;
      trx_woken_r <= 1'b0;
      reset_low_r <= 1'b1;
    end
    else
    begin
      mode_r <= mode_nxt;
      if (wr_mode && reg_wdata[1:0] == `LPM_CMD_SOFTRST && !enter_fs)
        cfg_r <= `LPM_CFG_RESET;
      else if (reg_wr && reg_addr == `LPM_REG_CFG)
      begin
        if (mode_r == `LPM_MODE_NORMAL || mode_r == `LPM_MODE_INIT)
          cfg_r <= reg_wdata[10:0];
      end
      if (reg_wr && (mode_r == `LPM_MODE_STOP) && reg_addr != `LPM_REG_MODE
          && reg_addr != `LPM_REG_STATUS)
        cmd_err_r <= 1'b1;
      else if (wr_mode && (mode_r == `LPM_MODE_INIT)
               && reg_wdata[1:0] == `LPM_CMD_SLEEP)
        cmd_err_r <= 1'b1;
      else if (wr_mode && (mode_r == `LPM_MODE_STOP)
               && reg_wdata[1:0] == `LPM_CMD_SLEEP)
        cmd_err_r <= 1'b1;
      else if (reg_wr && reg_addr == `LPM_REG_STATUS && reg_wdata[`LPM_STAT_CMDERR])
        cmd_err_r <= 1'b0;
      if (tsd_s)
        tsd_seen_r <= 1'b1;
      else if (mode_r != `LPM_MODE_FAILSAFE)
        tsd_seen_r <= 1'b0;
      if (enter_fs)
      begin
        wake_flags_r <= 3'h0;
        fo_r <= cfg_r[`LPM_CFG_FO];
        park_dis_r <= 1'b1;
      end
      else
      begin
        if (mode_r == `LPM_MODE_FAILSAFE || mode_r == `LPM_MODE_SLEEP
            || mode_r == `LPM_MODE_STOP)
          wake_flags_r <= wake_flags_r | {can_s, lin_s, wk_s && cfg_r[`LPM_CFG_WKIN]};
        else if (reg_wr && reg_addr == `LPM_REG_WAKE)
          wake_flags_r <= wake_flags_r & ~reg_wdata[2:0];
        if (reg_wr && reg_addr == `LPM_REG_RELEASE && mode_r != `LPM_MODE_STOP)
        begin
          fo_r <= 1'b0;
          park_dis_r <= 1'b0;
        end
      end
      trx_woken_r <= (mode_r == `LPM_MODE_FAILSAFE || mode_r == `LPM_MODE_SLEEP)
                     && (wake_flags_r[2:1] != 2'h0);
      if (mode_nxt == `LPM_MODE_SLEEP || mode_nxt == `LPM_MODE_RESTART
          || mode_nxt == `LPM_MODE_FAILSAFE)
        reset_low_r <= 1'b1;
      else
        reset_low_r <= 1'b0;
    end
  end

  // Function enables derived from mode and frozen configuration.
  assign main_regulator_output = (mode_r != `LPM_MODE_SLEEP)
                                 && (mode_r != `LPM_MODE_FAILSAFE);
  assign supervision_timer = (mode_r == `LPM_MODE_NORMAL || mode_r == `LPM_MODE_STOP
                              || mode_r == `LPM_MODE_INIT) && cfg_r[`LPM_CFG_WD];
  assign high_side_switches = (mode_r == `LPM_MODE_NORMAL || mode_r == `LPM_MODE_STOP
                               || mode_r == `LPM_MODE_SLEEP) && cfg_r[`LPM_CFG_HS];
  assign bridge_drivers = (mode_r == `LPM_MODE_NORMAL) && cfg_r[`LPM_CFG_BD];
  assign charge_pump = (mode_r == `LPM_MODE_NORMAL) && cfg_r[`LPM_CFG_CP];
  assign bridge_low_sides = brk_s && !park_dis_r && (mode_r == `LPM_MODE_NORMAL
                            || mode_r == `LPM_MODE_STOP || mode_r == `LPM_MODE_SLEEP);
  assign cyclic_sense = (mode_r == `LPM_MODE_NORMAL || mode_r == `LPM_MODE_STOP
                         || mode_r == `LPM_MODE_SLEEP) && cfg_r[`LPM_CFG_CSENSE];
  assign cyclic_wake = (mode_r == `LPM_MODE_NORMAL || mode_r == `LPM_MODE_STOP
                        || mode_r == `LPM_MODE_SLEEP) && cfg_r[`LPM_CFG_CWAKE];
  assign can_state = (mode_r == `LPM_MODE_FAILSAFE) ? TRX_WAKECAP :
                     (mode_r == `LPM_MODE_SLEEP) ? lp_trx(cfg_r[`LPM_CFG_CAN]) :
                     (mode_r == `LPM_MODE_RESTART) ? (trx_woken_r ? TRX_WOKEN :
                       lp_trx(cfg_r[`LPM_CFG_CAN])) :
                     (mode_r == `LPM_MODE_INIT) ? TRX_OFF :
                     (cfg_r[`LPM_CFG_CAN] ? TRX_ON : TRX_OFF);
  assign lin_state = (mode_r == `LPM_MODE_FAILSAFE) ? TRX_WAKECAP :
                     (mode_r == `LPM_MODE_SLEEP) ? lp_trx(cfg_r[`LPM_CFG_LIN]) :
                     (mode_r == `LPM_MODE_RESTART) ? (trx_woken_r ? TRX_WOKEN :
                       lp_trx(cfg_r[`LPM_CFG_LIN])) :
                     (mode_r == `LPM_MODE_INIT) ? TRX_OFF :
                     (cfg_r[`LPM_CFG_LIN] ? TRX_ON : TRX_OFF);
  assign wake_inputs_en = cfg_r[`LPM_CFG_WKIN]
                          && (mode_r != `LPM_MODE_INIT);
  assign fail_output_wake_pin = fo_r;
  assign parking_brake = cfg_r[`LPM_CFG_PARK] && !park_dis_r;
  assign reset_output_pin_n = ~reset_low_r;

  // Register read port with one cycle latency.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `LPM_REG_MODE: reg_rdata <= {13'h0000, mode_r};
        `LPM_REG_CFG: reg_rdata <= {5'h00, cfg_r};
        `LPM_REG_STATUS: reg_rdata <= {10'h000, !dwell_done, tsd_seen_r, cmd_err_r, mode_r};
        `LPM_REG_WAKE: reg_rdata <= {13'h0000, wake_flags_r};
        `LPM_REG_LSBRK: reg_rdata <= {14'h0000, park_dis_r, fo_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end
endmodule // lpm_mode_ctrl

//--- src/lpm_sync3.v
// Three-flop synchroniser for an asynchronous input level.
module lpm_sync3 (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire d_in,
  output reg q_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q_out <= s3_r;
    end
  end
endmodule // lpm_sync3

//--- src/lpm_timer.v
// Down counter that reports expiry of a loaded delay.
module lpm_timer #(
  parameter CNT_W = 27
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire load,
  input wire [CNT_W-1:0] load_val,
  input wire run,
  output wire expired
);
  reg [CNT_W-1:0] cnt_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= {CNT_W{1'b0}};
    else if (load)
      cnt_r <= load_val;
    else if (run && cnt_r != {CNT_W{1'b0}})
      cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
  end
  assign expired = (cnt_r == {CNT_W{1'b0}});
endmodule // lpm_timer

//--- tb/low_power_and_failsafe_mode_ctrl_tb.sv
// Self-checking bench for the low-power mode controller.
`include "lpm_map.vh"
module low_power_and_failsafe_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, fail_req, regulator_thermal_shutdown;
  logic can_wake, lin_wake, wake_inputs, brake_req;
  wire [3:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, main_regulator_output, supervision_timer, high_side_switches;
  wire bridge_drivers, bridge_low_sides, charge_pump, cyclic_sense, cyclic_wake;
  wire wake_inputs_en, fail_output_wake_pin, parking_brake, reset_output_pin_n;
  wire [1:0] can_state, lin_state;
  wire [10:0] en = {can_state, lin_state, main_regulator_output, supervision_timer,
    high_side_switches, bridge_drivers, charge_pump, cyclic_sense, cyclic_wake};
  int n_fail = 0;
  int samples_checked = 0;
  int n, k;
  logic [15:0] q;
  logic [10:0] c;
  lpm_mode_ctrl #(.DWELL_CYC(20), .TSD_CYC(40)) u_dut (.*);
  lpm_mcu_model u_mcu (.*);
  // Expected enables for Stop, Sleep and fail-safe.
  function automatic logic [10:0] exp_en(input logic [2:0] m, input logic [10:0] c);
    case (m)
      `LPM_MODE_STOP: exp_en = {4'h0, 1'b1, c[0], c[1], 2'h0, c[6], c[7]};
      `LPM_MODE_SLEEP: exp_en = {1'b0, c[4], 1'b0, c[5], 2'h0, c[1], 2'h0, c[6], c[7]};
      default: exp_en = 11'h280;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wait_up(output int n);
    n = 0;
    while (main_regulator_output !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    {rst_n, fail_req, regulator_thermal_shutdown, can_wake, lin_wake} = '0;
    {wake_inputs, brake_req} = '0;
    q = $urandom(32'h86680D89);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    u_mcu.rd(`LPM_REG_STATUS, q);
    chk("init", 16'h0000, q);
    for (k = 0; k < 2; k++)
    begin
      c = 11'($urandom);
      c[4] = c[4] | ~c[5];
      u_mcu.wr(`LPM_REG_MODE, 16'h0000);
      u_mcu.wr(`LPM_REG_RELEASE, 16'h0000);
      u_mcu.rd(`LPM_REG_LSBRK, q);
      chk("released", 16'h0000, q);
      u_mcu.wr(`LPM_REG_CFG, {5'h00, c});
      u_mcu.wr(`LPM_REG_WAKE, 16'h0007);
      u_mcu.wr(`LPM_REG_MODE, 16'h0001);
      #1 chk("stop_en", {5'h00, exp_en(`LPM_MODE_STOP, c) & 11'h07F}, {5'h00, en & 11'h07F});
      u_mcu.wr(`LPM_REG_CFG, 16'h0000);
      u_mcu.rd(`LPM_REG_STATUS, q);
      chk("stop_err", 16'h000A, q & 16'h000F);
      u_mcu.rd(`LPM_REG_CFG, q);
      chk("stop_cfg", {5'h00, c}, q);
      u_mcu.wr(`LPM_REG_STATUS, 16'h0008);
      u_mcu.wr(`LPM_REG_MODE, 16'h0000);
      u_mcu.wr(`LPM_REG_MODE, 16'h0002);
      #1 chk1("sleep_rst", 1'b0, reset_output_pin_n);
      chk("sleep_en", {5'h00, exp_en(`LPM_MODE_SLEEP, c)}, {5'h00, en});
      @(posedge clk) brake_req <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk1("brake", 1'b1, bridge_low_sides);
      @(posedge clk);
      brake_req <= 1'b0;
      fail_req <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk("fs_en", {5'h00, exp_en(`LPM_MODE_FAILSAFE, c)}, {5'h00, en});
      chk1("fs_fo", c[9], fail_output_wake_pin);
      chk1("fs_wk", c[8], wake_inputs_en);
      chk1("fs_park", 1'b0, parking_brake);
      @(posedge clk);
      fail_req <= 1'b0;
      can_wake <= (k == 0);
      lin_wake <= (k != 0);
      repeat (6) @(posedge clk);
      {can_wake, lin_wake} <= 2'b00;
      wait_up(n);
      chk1("fs_dwell", 1'b1, n >= 3 && n <= 20);
    end
    u_mcu.wr(`LPM_REG_MODE, 16'h0000);
    u_mcu.wr(`LPM_REG_CFG, 16'h07FF);
    u_mcu.wr(`LPM_REG_MODE, 16'h0003);
    u_mcu.rd(`LPM_REG_CFG, q);
    chk("srst_cfg", 16'h0000, q);
    u_mcu.rd(`LPM_REG_STATUS, q);
    chk("srst_mode", 16'h0000, q & 16'h0007);
    @(posedge clk) regulator_thermal_shutdown <= 1'b1;
    repeat (8) @(posedge clk);
    regulator_thermal_shutdown <= 1'b0;
    wait_up(n);
    chk1("tsd_wait", 1'b1, n >= 40 && n <= 52);
    tally_and_finish;
  end
endmodule // low_power_and_failsafe_mode_ctrl_tb

//--- tb/lpm_chk_properties.sv
// Assertions on the mode controller enables.
module lpm_chk (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fault input
  input wire fail_req,
  // Enables
  input wire main_regulator_output,
  input wire supervision_timer,
  input wire high_side_switches,
  input wire bridge_drivers,
  input wire charge_pump,
  input wire cyclic_sense,
  input wire cyclic_wake,
  input wire [1:0] can_state,
  input wire [1:0] lin_state,
  input wire parking_brake,
  input wire reset_output_pin_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire rst_ph = main_regulator_output && !reset_output_pin_n;
  wire fn_on = supervision_timer | high_side_switches | cyclic_sense | cyclic_wake;
  sequence fail_seq;
    $rose(fail_req) ##1 fail_req [*6];
  endsequence
  chk_bd_normal: assert property (
    (bridge_drivers | charge_pump) |-> main_regulator_output && reset_output_pin_n)
    else $error("bridge on in low mode");
  chk_restart_off: assert property (
    rst_ph |-> !fn_on && !bridge_drivers && !charge_pump) else $error("restart fn on");
  chk_restart_xcvr: assert property (
    rst_ph |-> can_state != 2'h2 && lin_state != 2'h2) else $error("restart xcvr on");
  chk_restart_len: assert property (
    rst_ph |-> ##[1:4] reset_output_pin_n) else $error("restart too long");
  chk_lowpwr_xcvr: assert property (
    !main_regulator_output |-> !supervision_timer && can_state < 2'h2 && lin_state < 2'h2)
    else $error("low mode xcvr");
  chk_fs_off: assert property (
    fail_seq |-> !main_regulator_output && !fn_on) else $error("failsafe fn on");
  chk_fs_xcvr: assert property (
    fail_seq |-> can_state == 2'h1 && lin_state == 2'h1) else $error("failsafe xcvr");
  chk_fs_park: assert property (
    fail_seq |-> !parking_brake) else $error("failsafe park");
  chk_fs_dwell: assert property (
    fail_seq |-> ##1 !main_regulator_output [*8]) else $error("failsafe left early");
  cov_fail: cover property (fail_seq);
  cov_restart: cover property (rst_ph);
  cov_sleep: cover property (!main_regulator_output && !reset_output_pin_n);
endmodule // lpm_chk
bind lpm_mode_ctrl lpm_chk u_chk (.*);

//--- tb/lpm_mcu_model.sv
// Microcontroller model that drives register cycles.
module lpm_mcu_model (
  // Clock
  input wire clk,
  // Register port
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Settings are written in full before any low-power command.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is taken in the one cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
endmodule // lpm_mcu_model
